/* File: rtl/aot_audio_output_transport.sv */
// Audio receive transport selection, lane control and master clock generation.
`timescale 1ns/1ns
`include "aot_params.svh"
module aot_audio_output_transport #(
  parameter int FRAME_W = `AOT_FRAME_W
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 link_clk,
  input  wire logic                 reg_wr_en,
  input  wire logic                 reg_rd_en,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  input  wire aot_pkg::aot_ser_cfg_t ser_cfg,
  input  wire logic                 repeater_pin,
  input  wire aot_pkg::aot_aud_in_t aud_in,
  output logic                      aud_ready,
  input  wire logic [3:0]           serial_in_data,
  input  wire logic                 serial_in_ws,
  output logic                      audio_bclk,
  output logic                      audio_ws,
  output logic                      audio_data_lane_a,
  output logic                      audio_data_lane_b,
  output logic                      audio_data_lane_c,
  output logic                      audio_data_lane_d,
  output logic                      audio_mclk,
  output logic                      island_fwd_en
);
  localparam int IDX_W = $clog2(FRAME_W);
  localparam int CFG_W = $bits(aot_pkg::aot_link_cfg_t);

  if (FRAME_W != `AOT_FRAME_W || FRAME_W != 2 * `AOT_SLOT_W) begin : g_bad_frame
    $error("FRAME_W must match the two-slot frame of the sample word");
  end

  // ---------------- System clock domain ----------------
  logic                       rst_sys_n;
  logic                       rep_s;
  logic [7:0]                 pll_ctl_reg;
  logic [7:0]                 mclk_sel_reg;
  logic [7:0]                 rdata_reg;
  logic                       frame_next;
  logic                       frame_mode_reg;
  aot_pkg::aot_lanes_t        lanes_next;
  aot_pkg::aot_lanes_t        lanes_reg;
  logic [`AOT_NUM_LANES-1:0]  lane_en;
  logic                       island_fwd_reg;
  logic [2:0]                 ratio_code;
  logic [2:0]                 code_diff;
  aot_pkg::aot_ratio_t        ratio_next;
  aot_pkg::aot_ratio_t        ratio_reg;
  logic                       meas_s;
  logic                       meas_d_reg;
  logic                       meas_edge;
  logic [11:0]                cnt_reg;
  logic [11:0]                meas_reg;
  logic [2:0]                 band_reg;
  logic                       range_err_reg;
  logic                       ack_s;
  logic                       req_tgl_reg;
  logic                       aud_ready_reg;
  logic                       accept;
  logic                       kind_match;
  aot_pkg::aot_word_t         word_next;
  aot_pkg::aot_word_t         hold_reg;
  aot_pkg::aot_link_cfg_t     cfg_sys;

  aot_sync2 #(.W(1)) u_rst_sys (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (1'b1),
    .q     (rst_sys_n)
  );

  aot_sync2 #(.W(1)) u_rep_sync (
    .clk   (clk),
    .rst_n (rst_sys_n),
    .d     (repeater_pin),
    .q     (rep_s)
  );

  // Control register writes.
  always_ff @(posedge clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      pll_ctl_reg  <= `AOT_PLL_CTL_RST;
      mclk_sel_reg <= `AOT_MCLK_SEL_RST;
    end else if (reg_wr_en) begin
      if (reg_addr == `AOT_OFS_PLL_CTL) begin
        pll_ctl_reg <= reg_wdata & `AOT_PLL_CTL_WMASK;
      end
      if (reg_addr == `AOT_OFS_MCLK_SEL) begin
        mclk_sel_reg <= reg_wdata & `AOT_MCLK_SEL_WMASK;
      end
    end
  end

  // Register reads show the live transport, lane and ratio state; other addresses read zero.
  always_ff @(posedge clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        `AOT_OFS_PLL_CTL:  rdata_reg <= {pll_ctl_reg[7], frame_mode_reg, lanes_reg,
                                         1'b0, pll_ctl_reg[2:0]};
        `AOT_OFS_MCLK_SEL: rdata_reg <= {mclk_sel_reg[7:4], range_err_reg, 1'b0, ratio_reg};
        default:           rdata_reg <= 8'h00;
      endcase
    end
  end

  always_comb begin
    frame_next = pll_ctl_reg[`AOT_BIT_CFG_OVR] | ser_cfg.frame_mode;
    if (frame_next) begin
      lanes_next = aot_pkg::AOT_LANES_1;
    end else if (ser_cfg.surround_on && ser_cfg.surround_cap && !ser_cfg.legacy_two_lane) begin
      lanes_next = aot_pkg::AOT_LANES_4;
    end else if (pll_ctl_reg[`AOT_BIT_TWO_LANE_4CH]) begin
      lanes_next = aot_pkg::AOT_LANES_2;
    end else begin
      lanes_next = aot_pkg::AOT_LANES_1;
    end
  end

  always_ff @(posedge clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      frame_mode_reg <= 1'b0;
      lanes_reg      <= aot_pkg::AOT_LANES_1;
      island_fwd_reg <= 1'b0;
    end else begin
      frame_mode_reg <= frame_next;
      lanes_reg      <= lanes_next;
      island_fwd_reg <= rep_s & ~frame_next;
    end
  end

  always_comb begin
    case (lanes_reg)
      aot_pkg::AOT_LANES_4: lane_en = 4'hF;
      aot_pkg::AOT_LANES_2: lane_en = 4'h3;
      default:              lane_en = 4'h1;
    endcase
  end

  // Bit-clock measurement: the link side toggles once per fixed count of bit clocks.
  assign meas_edge = meas_s ^ meas_d_reg;

  always_ff @(posedge clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      meas_d_reg <= 1'b0;
      cnt_reg    <= 12'h000;
      meas_reg   <= 12'hFFF;
    end else begin
      meas_d_reg <= meas_s;
      if (meas_edge) begin
        meas_reg <= cnt_reg;
        cnt_reg  <= 12'h000;
      end else if (cnt_reg != 12'hFFF) begin
        cnt_reg <= cnt_reg + 12'h001;
      end else begin
        meas_reg <= 12'hFFF;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      band_reg      <= 3'h0;
      range_err_reg <= 1'b1;
    end else begin
      if (meas_reg > 12'(`AOT_BAND1_CNT)) begin
        band_reg <= 3'h0;
      end else if (meas_reg > 12'(`AOT_BAND2_CNT)) begin
        band_reg <= 3'h1;
      end else if (meas_reg > 12'(`AOT_BAND3_CNT)) begin
        band_reg <= 3'h2;
      end else begin
        band_reg <= `AOT_BAND_TOP;
      end
      range_err_reg <= (meas_reg > 12'(`AOT_MIN_CNT)) | (meas_reg < 12'(`AOT_MAX_CNT));
    end
  end

  always_comb begin
    ratio_code = mclk_sel_reg[`AOT_POS_RATIO_CODE +: 3];
    code_diff  = 3'(ratio_code - band_reg);
    ratio_next = aot_pkg::AOT_RATIO_X2;
    if (mclk_sel_reg[`AOT_BIT_RATIO_OVR]) begin
      case (code_diff)
        3'h0:    ratio_next = aot_pkg::AOT_RATIO_X1;
        3'h1:    ratio_next = aot_pkg::AOT_RATIO_X2;
        3'h2:    ratio_next = aot_pkg::AOT_RATIO_X4;
        default: ratio_next = aot_pkg::AOT_RATIO_X2;
      endcase
      if (band_reg == `AOT_BAND_TOP && ratio_code == `AOT_CODE_X4_TOP) begin
        ratio_next = aot_pkg::AOT_RATIO_X4;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      ratio_reg <= aot_pkg::AOT_RATIO_X2;
    end else begin
      ratio_reg <= ratio_next;
    end
  end

  // Sample intake: one word is held until the link side acknowledges it.
  assign accept     = aud_in.valid & aud_ready_reg;
  assign kind_match = (aud_in.frame_kind == frame_mode_reg);

  always_comb begin
    word_next = '0;
    // frame words keep lane A only
    if (aud_in.frame_kind) begin
      word_next[0] = aud_in.lanes[0];
    end else begin
      for (int i = 0; i < `AOT_NUM_LANES; i++) begin
        word_next[i] = lane_en[i] ? aud_in.lanes[i] : '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      hold_reg      <= '0;
      req_tgl_reg   <= 1'b0;
      aud_ready_reg <= 1'b0;
    end else begin
      if (accept && kind_match) begin
        hold_reg      <= word_next;
        req_tgl_reg   <= ~req_tgl_reg;
        aud_ready_reg <= 1'b0;
      end else begin
        aud_ready_reg <= (req_tgl_reg == ack_s);
      end
    end
  end

  always_comb begin
    cfg_sys.pll_en  = ~pll_ctl_reg[`AOT_BIT_PLL_DIS];
    cfg_sys.ratio   = ratio_reg;
    cfg_sys.regen   = rep_s & pll_ctl_reg[`AOT_BIT_REGEN];
    cfg_sys.lane_en = lane_en;
  end

  assign reg_rdata     = rdata_reg;
  assign aud_ready     = aud_ready_reg;
  assign island_fwd_en = island_fwd_reg;

  // ---------------- Link clock domain ----------------
  logic                       rst_link_n;
  logic [CFG_W-1:0]           cfg_s;
  logic [CFG_W-1:0]           cfg_prev_reg;
  aot_pkg::aot_link_cfg_t     cfg_link_reg;
  logic [2:0]                 div_reg;
  logic [IDX_W-1:0]           idx_reg;
  logic [IDX_W-1:0]           idx_plus;
  logic                       req_s;
  logic                       ack_tgl_reg;
  logic                       meas_tgl_reg;
  logic                       shift;
  logic                       frame_end;
  logic                       load;
  logic [`AOT_NUM_LANES-1:0]  ser_msb;
  logic [4:0]                 pin_s;
  logic [`AOT_NUM_LANES-1:0]  lane_out_reg;
  logic                       bclk_reg;
  logic                       ws_reg;
  logic                       mclk_reg;

  aot_sync2 #(.W(1)) u_rst_link (
    .clk   (link_clk),
    .rst_n (rst_n),
    .d     (1'b1),
    .q     (rst_link_n)
  );

  // Configuration is quasi-static; it is taken only once two samples agree.
  aot_sync2 #(.W(CFG_W)) u_cfg_sync (
    .clk   (link_clk),
    .rst_n (rst_link_n),
    .d     (cfg_sys),
    .q     (cfg_s)
  );

  aot_sync2 #(.W(1)) u_req_sync (
    .clk   (link_clk),
    .rst_n (rst_link_n),
    .d     (req_tgl_reg),
    .q     (req_s)
  );

  aot_sync2 #(.W(1)) u_ack_sync (
    .clk   (clk),
    .rst_n (rst_sys_n),
    .d     (ack_tgl_reg),
    .q     (ack_s)
  );

  aot_sync2 #(.W(1)) u_meas_sync (
    .clk   (clk),
    .rst_n (rst_sys_n),
    .d     (meas_tgl_reg),
    .q     (meas_s)
  );

  aot_sync2 #(.W(5)) u_pin_sync (
    .clk   (link_clk),
    .rst_n (rst_link_n),
    .d     ({serial_in_ws, serial_in_data}),
    .q     (pin_s)
  );

  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      cfg_prev_reg <= '0;
      cfg_link_reg <= '{pll_en: 1'b1, ratio: aot_pkg::AOT_RATIO_X2, regen: 1'b0,
                        lane_en: 4'h1};
    end else begin
      cfg_prev_reg <= cfg_s;
      // At least one lane is always enabled, so an all-zero sample is only the flush of reset.
      if (cfg_s == cfg_prev_reg && cfg_s != '0) begin
        cfg_link_reg <= aot_pkg::aot_link_cfg_t'(cfg_s);
      end
    end
  end

  assign shift     = (div_reg == 3'h7);
  assign frame_end = shift & (&idx_reg);
  assign load      = frame_end & (req_s != ack_tgl_reg);
  assign idx_plus  = IDX_W'(idx_reg + 1'b1);

  // The link clock runs at eight times the bit clock; the divider sets every edge.
  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      div_reg      <= 3'h0;
      idx_reg      <= '0;
      meas_tgl_reg <= 1'b0;
    end else begin
      div_reg <= div_reg + 3'h1;
      if (shift) begin
        idx_reg <= idx_plus;
        if (idx_reg[2:0] == 3'h7) begin
          meas_tgl_reg <= ~meas_tgl_reg;
        end
      end
    end
  end

  // The held word is only read while the request is outstanding, so it is stable here.
  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      ack_tgl_reg <= 1'b0;
    end else if (load) begin
      ack_tgl_reg <= ~ack_tgl_reg;
    end
  end

  for (genvar g = 0; g < `AOT_NUM_LANES; g++) begin : g_lane
    aot_lane_ser #(.W(FRAME_W)) u_ser (
      .clk   (link_clk),
      .rst_n (rst_link_n),
      .shift (shift),
      .load  (load),
      .word  (hold_reg[g]),
      .msb   (ser_msb[g])
    );
  end

  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      lane_out_reg <= '0;
      bclk_reg     <= 1'b0;
      ws_reg       <= 1'b0;
    end else begin
      bclk_reg <= div_reg[2];
      if (cfg_link_reg.regen) begin
        lane_out_reg <= pin_s[3:0];
        ws_reg       <= pin_s[4];
      end else begin
        lane_out_reg <= cfg_link_reg.lane_en & ser_msb;
        ws_reg       <= idx_plus[IDX_W-1];
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      mclk_reg <= 1'b0;
    end else if (!cfg_link_reg.pll_en) begin
      mclk_reg <= 1'b0;
    end else begin
      case (cfg_link_reg.ratio)
        aot_pkg::AOT_RATIO_X1: mclk_reg <= div_reg[2];
        aot_pkg::AOT_RATIO_X4: mclk_reg <= div_reg[0];
        default:               mclk_reg <= div_reg[1];
      endcase
    end
  end

  assign audio_bclk        = bclk_reg;
  assign audio_ws          = ws_reg;
  assign audio_data_lane_a = lane_out_reg[0];
  assign audio_data_lane_b = lane_out_reg[1];
  assign audio_data_lane_c = lane_out_reg[2];
  assign audio_data_lane_d = lane_out_reg[3];
  assign audio_mclk        = mclk_reg;

  // ---------------- Checks ----------------
  AST_OVR_FRAME: assert property (@(posedge clk) disable iff (!rst_sys_n)
    pll_ctl_reg[`AOT_BIT_CFG_OVR] |=> frame_mode_reg && lanes_reg == aot_pkg::AOT_LANES_1)
    else $error("override did not force single-lane frame transport");

  AST_AUTO_MODE: assert property (@(posedge clk) disable iff (!rst_sys_n)
    !pll_ctl_reg[`AOT_BIT_CFG_OVR] |=> frame_mode_reg == $past(ser_cfg.frame_mode))
    else $error("transport mode did not follow the serializer");

  AST_SURROUND: assert property (@(posedge clk) disable iff (!rst_sys_n)
    lanes_reg == aot_pkg::AOT_LANES_4 |-> !frame_mode_reg && $past(ser_cfg.surround_cap))
    else $error("four lanes active without island transport and capable serializer");

  AST_LEGACY: assert property (@(posedge clk) disable iff (!rst_sys_n)
    ser_cfg.legacy_two_lane |=> lanes_reg != aot_pkg::AOT_LANES_4)
    else $error("legacy serializer produced four lanes");

  AST_TWO_LANE: assert property (@(posedge clk) disable iff (!rst_sys_n)
    lanes_reg == aot_pkg::AOT_LANES_2 |-> $past(pll_ctl_reg[`AOT_BIT_TWO_LANE_4CH]))
    else $error("two-lane mode entered without software setting");

  AST_RATIO_DEF: assert property (@(posedge clk) disable iff (!rst_sys_n)
    !mclk_sel_reg[`AOT_BIT_RATIO_OVR] |=> ratio_reg == aot_pkg::AOT_RATIO_X2)
    else $error("ratio changed while override clear");

  AST_RATIO_BASE: assert property (@(posedge clk) disable iff (!rst_sys_n)
    mclk_sel_reg[`AOT_BIT_RATIO_OVR] && ratio_code == band_reg
      |=> ratio_reg == aot_pkg::AOT_RATIO_X1)
    else $error("base code did not select ratio one");

  AST_RATIO_TOP: assert property (@(posedge clk) disable iff (!rst_sys_n)
    mclk_sel_reg[`AOT_BIT_RATIO_OVR] && band_reg == `AOT_BAND_TOP
      && ratio_code == `AOT_CODE_X4_TOP |=> ratio_reg == aot_pkg::AOT_RATIO_X4)
    else $error("alternate top-band code did not select ratio four");

  AST_READY_DROP: assert property (@(posedge clk) disable iff (!rst_sys_n)
    accept && kind_match |=> !aud_ready_reg && $changed(req_tgl_reg))
    else $error("accepted sample did not raise a request");

  AST_MCLK_OFF: assert property (@(posedge link_clk) disable iff (!rst_link_n)
    !cfg_link_reg.pll_en |=> !mclk_reg [*2])
    else $error("master clock running while PLL disabled");

  AST_MCLK_X1: assert property (@(posedge link_clk) disable iff (!rst_link_n)
    cfg_link_reg.pll_en && cfg_link_reg.ratio == aot_pkg::AOT_RATIO_X1
      |=> mclk_reg == bclk_reg)
    else $error("ratio-one master clock differs from bit clock");

  AST_LANE_IDLE: assert property (@(posedge link_clk) disable iff (!rst_link_n)
    !cfg_link_reg.regen && !cfg_link_reg.lane_en[3] |=> !lane_out_reg[3])
    else $error("disabled lane carried data");
endmodule

/* File: rtl/aot_params.svh */
// Offsets, field positions, reset values and timing counts of the audio output block.
`ifndef AOT_PARAMS_SVH
`define AOT_PARAMS_SVH
`define AOT_OFS_PLL_CTL      8'h2B
`define AOT_OFS_MCLK_SEL     8'h3A
`define AOT_PLL_CTL_RST      8'h00
`define AOT_MCLK_SEL_RST     8'h00
`define AOT_PLL_CTL_WMASK    8'h87
`define AOT_MCLK_SEL_WMASK   8'hF0
`define AOT_BIT_PLL_DIS      7
`define AOT_BIT_CFG_OVR      0
`define AOT_BIT_TWO_LANE_4CH 1
`define AOT_BIT_REGEN        2
`define AOT_BIT_STAT_FRAME   6
`define AOT_POS_STAT_LANES   4
`define AOT_BIT_RATIO_OVR    7
`define AOT_POS_RATIO_CODE   4
`define AOT_BIT_RANGE_ERR    3
`define AOT_CODE_X4_TOP      3'h6
`define AOT_BAND_TOP         3'h3
`define AOT_NUM_LANES        4
`define AOT_SLOT_W           32
`define AOT_FRAME_W          64
`define AOT_LINK_PER_BCLK    8
`define AOT_SYS_CLK_KHZ      250000
`define AOT_MEAS_BCLKS       8
`define AOT_BAND1_KHZ        1800
`define AOT_BAND2_KHZ        3800
`define AOT_BAND3_KHZ        7500
`define AOT_BCLK_MIN_KHZ     1000
`define AOT_BCLK_MAX_KHZ     13000
`define AOT_BAND1_CNT        (`AOT_MEAS_BCLKS * `AOT_SYS_CLK_KHZ / `AOT_BAND1_KHZ)
`define AOT_BAND2_CNT        (`AOT_MEAS_BCLKS * `AOT_SYS_CLK_KHZ / `AOT_BAND2_KHZ)
`define AOT_BAND3_CNT        (`AOT_MEAS_BCLKS * `AOT_SYS_CLK_KHZ / `AOT_BAND3_KHZ)
`define AOT_MIN_CNT          (`AOT_MEAS_BCLKS * `AOT_SYS_CLK_KHZ / `AOT_BCLK_MIN_KHZ)
`define AOT_MAX_CNT          (`AOT_MEAS_BCLKS * `AOT_SYS_CLK_KHZ / `AOT_BCLK_MAX_KHZ)
`endif

/* File: rtl/aot_pkg.sv */
// Types shared by the audio output block and its helpers.
`include "aot_params.svh"
package aot_pkg;
  typedef enum logic [1:0] {
    AOT_LANES_1 = 2'h0,
    AOT_LANES_2 = 2'h1,
    AOT_LANES_4 = 2'h2
  } aot_lanes_t;

  typedef enum logic [1:0] {
    AOT_RATIO_X1 = 2'h0,
    AOT_RATIO_X2 = 2'h1,
    AOT_RATIO_X4 = 2'h2
  } aot_ratio_t;

  typedef logic [`AOT_NUM_LANES-1:0][`AOT_FRAME_W-1:0] aot_word_t;

  typedef struct packed {
    logic frame_mode;
    logic surround_cap;
    logic legacy_two_lane;
    logic surround_on;
  } aot_ser_cfg_t;

  typedef struct packed {
    logic      valid;
    logic      frame_kind;
    aot_word_t lanes;
  } aot_aud_in_t;

  typedef struct packed {
    logic                      pll_en;
    aot_ratio_t                ratio;
    logic                      regen;
    logic [`AOT_NUM_LANES-1:0] lane_en;
  } aot_link_cfg_t;
endpackage

/* File: rtl/aot_sync2.sv */
// Two-flop synchroniser with asynchronous clear, also used as a reset synchroniser.
`timescale 1ns/1ns
module aot_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end

  assign q = s2_reg;
endmodule

/* File: rtl/aot_lane_ser.sv */
// Serialiser for one audio data lane: loads a two-slot frame and shifts it out MSB first.
`timescale 1ns/1ns
module aot_lane_ser #(
  parameter int W = 64
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         shift,
  input  wire logic         load,
  input  wire logic [W-1:0] word,
  output logic              msb
);
  logic [W-1:0] sr_reg;

  // Zeros are shifted in so that a frame without a fresh sample plays silence.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_reg <= '0;
    end else if (load) begin
      sr_reg <= word;
    end else if (shift) begin
      sr_reg <= {sr_reg[W-2:0], 1'b0};
    end
  end

  assign msb = sr_reg[W-1];
endmodule

/* File: verif/aot_codec_model.sv */
// Codec model: counts master clock edges and notes activity on the data lanes.
`timescale 1ns/1ns
module aot_codec_model (
  input  wire logic       bclk,
  input  wire logic       mclk,
  input  wire logic       lane_a,
  input  wire logic [2:0] lanes_bcd,
  input  wire logic       clr,
  output int              total,
  output logic            seen_a,
  output logic            seen_bcd
);
  initial total = 0;
  always @(posedge mclk) total <= total + 1;
  always @(posedge bclk or posedge clr) begin
    if (clr) begin
      seen_a   <= 1'b0;
      seen_bcd <= 1'b0;
    end else begin
      seen_a   <= seen_a | lane_a;
      seen_bcd <= seen_bcd | (|lanes_bcd);
    end
  end
endmodule

/* File: verif/aot_audio_output_transport_mclk_bench.sv */
// Bench for transport selection, lane control and master clock ratio.
`timescale 1ns/1ns
module aot_audio_output_transport_mclk_bench;
  logic clk = 0, lclk = 0, rst_n = 0, wr = 0, rd = 0, rep = 0, clr = 0, rp = 0, siw = 0;
  logic [3:0] sid = 4'h0;
  logic [7:0] ad = 0, wd = 0, rdat;
  aot_pkg::aot_ser_cfg_t cfg = '0;
  aot_pkg::aot_aud_in_t ain = '0;
  logic rdy, bclk, ws, la, lb, lc, ld, mclk, fwd, sa, sb;
  int total, n_fail = 0, compares = 0;
  logic [7:0] q[$];
  always #2 clk = ~clk;
  always #3 lclk = ~lclk;
  aot_audio_output_transport u_aot_audio_output_transport (.clk(clk), .rst_n(rst_n),
    .link_clk(lclk), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(ad), .reg_wdata(wd),
    .reg_rdata(rdat), .ser_cfg(cfg), .repeater_pin(rep), .aud_in(ain), .aud_ready(rdy),
    .serial_in_data(sid), .serial_in_ws(siw), .audio_bclk(bclk), .audio_ws(ws),
    .audio_data_lane_a(la), .audio_data_lane_b(lb), .audio_data_lane_c(lc),
    .audio_data_lane_d(ld), .audio_mclk(mclk), .island_fwd_en(fwd));
  aot_codec_model u_aot_codec_model (.bclk(bclk), .mclk(mclk), .lane_a(la),
    .lanes_bcd({lb, lc, ld}), .clr(clr), .total(total), .seen_a(sa), .seen_bcd(sb));
  task automatic conclude;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic c);
    compares++;
    if (c !== 1'b1) begin n_fail++; $display("[FAIL] %0t check", $time); end
  endtask
  always @(posedge clk) begin
    if (rp) begin
      compares++;
      if (rdat !== q[0]) begin n_fail++; $display("[FAIL] %0t rd %h/%h", $time, rdat, q[0]); end
      void'(q.pop_front());
    end
    rp <= rd;
  end
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk); ad = a; wd = d; wr = 1;
    @(negedge clk); wr = 0; repeat (12) @(negedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk); ad = a; rd = 1; q.push_back(e);
    @(negedge clk); rd = 0; repeat (2) @(negedge clk);
  endtask
  task automatic ratio(input int m);
    int n0;
    repeat (4) @(posedge bclk); n0 = total;
    repeat (16) @(posedge bclk);
    chk(total - n0 >= 16 * m - 1 && total - n0 <= 16 * m + 1);
  endtask
  task automatic send(input logic k);
    int i;
    @(negedge clk); clr = 1;
    @(negedge clk); clr = 0; ain.lanes = {$urandom, $urandom, $urandom, $urandom,
      $urandom, $urandom, $urandom, $urandom} | {4{64'h8000000000000000}};
    ain.frame_kind = k; ain.valid = 1;
    for (i = 0; i < 3000 && !rdy; i++) @(negedge clk);
    @(negedge clk); ain.valid = 0; chk(i < 3000);
    if (i < 3000) repeat (200) @(posedge bclk);
    else conclude();
  endtask
  initial begin
    int i;
    logic [7:0] dat[5] = '{8'hB0, 8'hC0, 8'hD0, 8'hE0, 8'hF0};
    int rr[5] = '{0, 1, 2, 2, 1};
    logic fr, ov, b1;
    logic [1:0] ln;
    void'($urandom(18099));
    fork begin #400000; n_fail++; conclude(); end join_none
    repeat (16) @(negedge clk); rst_n = 1; repeat (6) @(negedge clk);
    rreg(8'h2B, 8'h00); rreg(8'h3A, 8'h09); rreg(8'h55, 8'h00); ratio(2);
    $display("reset test done");
    wreg(8'h3A, 8'h80);
    for (i = 0; i < 5; i++) begin
      wreg(8'h3A, dat[i]); rreg(8'h3A, dat[i] | 8'h08 | 8'(rr[i]));
      ratio(1 << rr[i]);
    end
    wreg(8'h3A, 8'h50); rreg(8'h3A, 8'h59); ratio(2);
    $display("ratio test done");
    wreg(8'h2B, 8'hFF); rreg(8'h2B, 8'hC7); ratio(0); wreg(8'h2B, 8'h00);
    $display("pll test done");
    for (i = 0; i < 12; i++) begin
      cfg = 4'($urandom); rep = 1'($urandom); ov = 1'($urandom); b1 = 1'($urandom);
      fr = ov | cfg.frame_mode;
      ln = fr ? 2'h0 : (cfg.surround_on & cfg.surround_cap & !cfg.legacy_two_lane) ? 2'h2
        : {1'b0, b1};
      wreg(8'h2B, {6'h0, b1, ov}); rreg(8'h2B, {1'b0, fr, ln, 2'h0, b1, ov});
      chk(fwd === (rep & !fr));
    end
    $display("lane test done");
    cfg = '0; rep = 1; wreg(8'h2B, 8'h04); rreg(8'h2B, 8'h04);
    for (i = 0; i < 4; i++) begin
      sid = 4'($urandom); siw = 1'($urandom); repeat (8) @(negedge clk);
      chk({ws, ld, lc, lb, la} === {siw, sid});
    end
    sid = 4'h0; siw = 0;
    $display("regen test done");
    cfg = '0; wreg(8'h2B, 8'h01); send(1); chk(sa === 1 && sb === 0);
    cfg = 4'h5; wreg(8'h2B, 8'h00); send(0); chk(sa === 1 && sb === 1);
    $display("data test done");
    conclude();
  end
endmodule
